/* logic/sscu_consts.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef SSCU_CONSTS_SVH
`define SSCU_CONSTS_SVH

`define SSCU_OFF_SRC_A      8'h00
`define SSCU_OFF_SRC_B      8'h10
`define SSCU_OFF_CTRL       8'h20
`define SSCU_OFF_LEN_DATA   8'h24
`define SSCU_OFF_LEN_ACC    8'h28
`define SSCU_OFF_CMD        8'h2c
`define SSCU_OFF_RES        8'h30
`define SSCU_OFF_COUNT      8'h40

`define SSCU_CTRL_IMM_LSB   0
`define SSCU_CTRL_OP_LSB    8
`define SSCU_CMD_GO_BIT     0
`define SSCU_STAT_BUSY_BIT  0
`define SSCU_STAT_DONE_BIT  1

`define SSCU_CTRL_RST       32'h0000_0000
`define SSCU_LEN_RST        32'h0000_0000
`define SSCU_DATA_RST       128'h0

`define SSCU_RUN_CYCLES     1
`define SSCU_HTRANS_NONSEQ  2'h2
`define SSCU_HSIZE_WORD     3'h2
`define SSCU_ELEMS_BYTE     5'h10
`define SSCU_ELEMS_WORD     5'h08

`endif

/* logic/sscu_pkg.sv */
// Types shared by the string compare unit.
`default_nettype none
package sscu_pkg;

    typedef enum logic [2:0] {
        OP_QUAD_EQ   = 3'h0,
        OP_QUAD_GT   = 3'h1,
        OP_PACK_USDW = 3'h2,
        OP_EXP_INDEX = 3'h3,
        OP_EXP_MASK  = 3'h4,
        OP_IMP_INDEX = 3'h5,
        OP_IMP_MASK  = 3'h6
    } sscu_op_t;

    typedef enum logic [1:0] {
        MODE_EQ_ANY     = 2'h0,
        MODE_RANGES     = 2'h1,
        MODE_EQ_EACH    = 2'h2,
        MODE_EQ_ORDERED = 2'h3
    } sscu_mode_t;

    typedef struct packed {
        logic       rsvd;
        logic       out_sel;
        logic [1:0] polarity;
        sscu_mode_t mode;
        logic       sgn;
        logic       word;
    } sscu_imm_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } sscu_state_t;

    typedef struct packed {
        logic       valid;
        logic       wr;
        logic       ok;
        logic [7:0] addr;
    } sscu_dphase_t;

    typedef logic signed [16:0] sscu_elem_t;

endpackage
`default_nettype wire

/* logic/sscu_top.sv */
// Packed-integer compare datapath with string compare engine on AHB-Lite.
//
// Contract
// [RULE_01] Quadword lane equality over 128 bits.
// [RULE_02] Pack dwords to words, unsigned saturation.
// [RULE_03] Quadword lane greater-than over 128 bits.
// [RULE_04] Operands hold sixteen bytes or eight words.
// [RULE_05] Immediate selects format, mode, processing, output.
// [RULE_06] Elements bytes or words, signed or unsigned.
// [RULE_07] Four compare modes on elements.
// [RULE_08] All element pairs compared, up to 256.
// [RULE_09] Aggregate pair results, then selectable processing.
// [RULE_10] Index to count register, mask to vector.
// [RULE_11] Index search from either end.
// [RULE_12] Mask as bits or expanded elements.
// [RULE_13] Explicit lengths from data and accumulator.
// [RULE_14] Implicit length ends at first null.
// [RULE_15] Partial fragments bounded by length or null.
// [RULE_16] No alignment fault on any operand.
// [RULE_17] Sources come from registers or memory; here both are registers written over the bus.
// [RULE_18] Lane results all ones or zeros, signed.
// [RULE_19] Pack clamps negatives to zero, caps 65535.
`timescale 1ns/1ps
`include "sscu_consts.svh"
`default_nettype none
module sscu_top #(
    parameter int ELEMS = 16
) (
    input  wire logic        clk,
    input  wire logic        ce,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);

    ////////////////////////////////////////////////////////////////////////
    logic                 rst_meta_ff;
    logic                 rst_sync_ff;

    // The synchroniser runs without the clock enable so reset always lands.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [127:0]          src_a_ff;
    logic [127:0]          src_b_ff;
    logic [31:0]           ctrl_ff;
    logic [31:0]           len_data_ff;
    logic [31:0]           len_acc_ff;
    logic [127:0]          res_ff;
    logic [31:0]           cnt_ff;
    logic                  done_ff;
    logic [31:0]           hrdata_ff;
    sscu_pkg::sscu_state_t state_ff;
    sscu_pkg::sscu_dphase_t dph_ff;
    logic [127:0]          nxt_src_a;
    logic [127:0]          nxt_src_b;
    logic [31:0]           nxt_ctrl;
    logic [31:0]           nxt_len_data;
    logic [31:0]           nxt_len_acc;
    logic [127:0]          nxt_res;
    logic [31:0]           nxt_cnt;
    logic                  nxt_done;
    logic [31:0]           nxt_hrdata;
    sscu_pkg::sscu_state_t nxt_state;
    sscu_pkg::sscu_dphase_t nxt_dph;

    sscu_pkg::sscu_imm_t   imm;
    sscu_pkg::sscu_op_t    op;
    logic [127:0]          calc_vec;
    logic [4:0]            calc_idx;
    logic                  accept;
    logic                  wr_go;

    assign imm = sscu_pkg::sscu_imm_t'(ctrl_ff[`SSCU_CTRL_IMM_LSB +: 8]); // [RULE_05]
    assign op  = sscu_pkg::sscu_op_t'(ctrl_ff[`SSCU_CTRL_OP_LSB +: 3]);
    assign hreadyout = ce;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;
    assign accept    = hsel & (htrans == `SSCU_HTRANS_NONSEQ) & hready;

    ////////////////////////////////////////////////////////////////////////
    // Element extraction, null flags and the full pair matrix.
    sscu_pkg::sscu_elem_t ea [ELEMS];
    sscu_pkg::sscu_elem_t eb [ELEMS];
    logic [ELEMS-1:0]     nul_a;
    logic [ELEMS-1:0]     nul_b;
    logic [ELEMS-1:0]     eqm [ELEMS];
    logic [ELEMS-1:0]     gem [ELEMS];
    logic [ELEMS-1:0]     lem [ELEMS];

    genvar gi;
    genvar gj;
    generate
        for (gi = 0; gi < ELEMS; gi++) begin : g_elem
            logic [7:0]  ba;
            logic [7:0]  bb;
            logic [15:0] wa;
            logic [15:0] wb;
            assign ba = src_a_ff[8*gi +: 8];
            assign bb = src_b_ff[8*gi +: 8];
            assign wa = (gi < ELEMS/2) ? src_a_ff[16*(gi%(ELEMS/2)) +: 16]
                                       : 16'h0000;
            assign wb = (gi < ELEMS/2) ? src_b_ff[16*(gi%(ELEMS/2)) +: 16]
                                       : 16'h0000;
            // Sign comes from the element's top bit only in signed mode.
            assign ea[gi] = imm.word ? {imm.sgn & wa[15], wa}
                                     : {{9{imm.sgn & ba[7]}}, ba}; // [RULE_06]
            assign eb[gi] = imm.word ? {imm.sgn & wb[15], wb}
                                     : {{9{imm.sgn & bb[7]}}, bb}; // [RULE_06]
            assign nul_a[gi] = imm.word ? (wa == 16'h0000) : (ba == 8'h00);
            assign nul_b[gi] = imm.word ? (wb == 16'h0000) : (bb == 8'h00);
            for (gj = 0; gj < ELEMS; gj++) begin : g_pair
                assign eqm[gi][gj] = (eb[gj] == ea[gi]); // [RULE_08]
                assign gem[gi][gj] = (eb[gj] >= ea[gi]); // [RULE_08]
                assign lem[gi][gj] = (eb[gj] <= ea[gi]); // [RULE_08]
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Valid element counts, then aggregation and output forming.
    logic [4:0]        n_el;
    logic [4:0]        la;
    logic [4:0]        lb;
    logic [31:0]       abs_a;
    logic [31:0]       abs_b;
    logic [ELEMS-1:0]  va;
    logic [ELEMS-1:0]  vb;
    logic [ELEMS-1:0]  int1;
    logic [ELEMS-1:0]  int2;
    logic              explicit_len;
    logic              acc;

    assign explicit_len = (op == sscu_pkg::OP_EXP_INDEX) |
                          (op == sscu_pkg::OP_EXP_MASK);

    always_comb begin
        n_el  = imm.word ? `SSCU_ELEMS_WORD : `SSCU_ELEMS_BYTE; // [RULE_04]
        abs_a = len_acc_ff[31] ? (32'h0 - len_acc_ff) : len_acc_ff;
        abs_b = len_data_ff[31] ? (32'h0 - len_data_ff) : len_data_ff;
        la = n_el;
        lb = n_el;
        if (explicit_len) begin
            // Lengths are magnitudes saturated at the element count.
            la = (abs_a > 32'(n_el)) ? n_el : abs_a[4:0]; // [RULE_13]
            lb = (abs_b > 32'(n_el)) ? n_el : abs_b[4:0]; // [RULE_13]
        end else begin
            for (int i = ELEMS - 1; i >= 0; i--) begin
                if (i < int'(n_el) && nul_a[i]) la = 5'(i); // [RULE_14]
                if (i < int'(n_el) && nul_b[i]) lb = 5'(i); // [RULE_14]
            end
        end
        for (int i = 0; i < ELEMS; i++) begin
            va[i] = (i < int'(la)); // [RULE_15]
            vb[i] = (i < int'(lb)); // [RULE_15]
        end
    end

    always_comb begin
        int1 = '0;
        acc  = 1'b0;
        for (int j = 0; j < ELEMS; j++) begin
            unique case (imm.mode) // [RULE_07]
                sscu_pkg::MODE_EQ_ANY: begin
                    acc = 1'b0;
                    for (int i = 0; i < ELEMS; i++) begin
                        acc = acc | (va[i] & vb[j] & eqm[i][j]);
                    end
                end
                sscu_pkg::MODE_RANGES: begin
                    acc = 1'b0;
                    for (int i = 0; i < ELEMS; i += 2) begin
                        acc = acc | (va[i] & va[i+1] & vb[j] &
                                     gem[i][j] & lem[i+1][j]);
                    end
                end
                sscu_pkg::MODE_EQ_EACH: begin
                    // Two invalid elements count as a match.
                    acc = (va[j] & vb[j]) ? eqm[j][j] : ~(va[j] | vb[j]);
                end
                sscu_pkg::MODE_EQ_ORDERED: begin
                    acc = 1'b1;
                    for (int i = 0; i < ELEMS; i++) begin
                        if (i + j < ELEMS && va[i]) begin
                            acc = acc & vb[i+j] & eqm[i][i+j];
                        end
                    end
                end
            endcase
            int1[j] = acc & (j < int'(n_el)); // [RULE_09]
        end
    end

    always_comb begin
        unique case (imm.polarity) // [RULE_09]
            2'h1:    int2 = ~int1;
            2'h3:    int2 = int1 ^ vb;
            default: int2 = int1;
        endcase
        for (int i = 0; i < ELEMS; i++) begin
            if (i >= int'(n_el)) int2[i] = 1'b0;
        end
        calc_idx = n_el;
        if (imm.out_sel) begin
            for (int i = 0; i < ELEMS; i++) begin
                if (int2[i]) calc_idx = 5'(i); // [RULE_11]
            end
        end else begin
            for (int i = ELEMS - 1; i >= 0; i--) begin
                if (int2[i]) calc_idx = 5'(i); // [RULE_11]
            end
        end
    end

    always_comb begin
        logic [31:0] dw;
        dw       = 32'h0000_0000;
        calc_vec = '0;
        unique case (op)
            sscu_pkg::OP_QUAD_EQ: begin
                for (int q = 0; q < 2; q++) begin
                    calc_vec[64*q +: 64] = {64{src_a_ff[64*q +: 64] ==
                                               src_b_ff[64*q +: 64]}}; // [RULE_01] [RULE_18]
                end
            end
            sscu_pkg::OP_QUAD_GT: begin
                for (int q = 0; q < 2; q++) begin
                    calc_vec[64*q +: 64] =
                        {64{$signed(src_a_ff[64*q +: 64]) >
                            $signed(src_b_ff[64*q +: 64])}}; // [RULE_03] [RULE_18]
                end
            end
            sscu_pkg::OP_PACK_USDW: begin
                for (int d = 0; d < 8; d++) begin
                    dw = (d < 4) ? src_a_ff[32*d +: 32]
                                 : src_b_ff[32*(d%4) +: 32];
                    if (dw[31]) begin
                        calc_vec[16*d +: 16] = 16'h0000; // [RULE_19]
                    end else if (dw[30:16] != 15'h0000) begin
                        calc_vec[16*d +: 16] = 16'hffff; // [RULE_19]
                    end else begin
                        calc_vec[16*d +: 16] = dw[15:0]; // [RULE_02]
                    end
                end
            end
            default: begin
                if (!imm.out_sel) begin
                    calc_vec[ELEMS-1:0] = int2; // [RULE_12]
                end else begin
                    for (int i = 0; i < ELEMS; i++) begin
                        if (imm.word && i < ELEMS/2) begin
                            calc_vec[16*i +: 16] = {16{int2[i]}}; // [RULE_12]
                        end else if (!imm.word) begin
                            calc_vec[8*i +: 8] = {8{int2[i]}}; // [RULE_12]
                        end
                    end
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: zero wait states while ce is high (hreadyout follows ce), registered read data.
    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a[7:4] == `SSCU_OFF_SRC_A >> 4) v = src_a_ff[32*a[3:2] +: 32];
        if (a[7:4] == `SSCU_OFF_SRC_B >> 4) v = src_b_ff[32*a[3:2] +: 32];
        if (a[7:4] == `SSCU_OFF_RES >> 4)   v = res_ff[32*a[3:2] +: 32];
        if (a == `SSCU_OFF_CTRL)     v = ctrl_ff;
        if (a == `SSCU_OFF_LEN_DATA) v = len_data_ff;
        if (a == `SSCU_OFF_LEN_ACC)  v = len_acc_ff;
        if (a == `SSCU_OFF_COUNT)    v = cnt_ff;
        if (a == `SSCU_OFF_CMD) begin
            v[`SSCU_STAT_BUSY_BIT] = (state_ff == sscu_pkg::ST_RUN);
            v[`SSCU_STAT_DONE_BIT] = done_ff;
        end
        return v;
    endfunction

    always_comb begin
        logic wr;
        wr = dph_ff.valid & dph_ff.wr & dph_ff.ok;
        nxt_dph.valid = accept;
        nxt_dph.wr    = hwrite;
        nxt_dph.ok    = (hsize == `SSCU_HSIZE_WORD) &
                        (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0);
        nxt_dph.addr  = haddr[7:0];
        nxt_hrdata    = hrdata_ff;
        if (accept && !hwrite) begin
            nxt_hrdata = nxt_dph.ok ? rd_mux(haddr[7:0]) : 32'h0000_0000;
        end
        nxt_src_a    = src_a_ff;
        nxt_src_b    = src_b_ff;
        nxt_ctrl     = ctrl_ff;
        nxt_len_data = len_data_ff;
        nxt_len_acc  = len_acc_ff;
        wr_go        = 1'b0;
        if (wr) begin
            if (dph_ff.addr[7:4] == `SSCU_OFF_SRC_A >> 4) begin
                nxt_src_a[32*dph_ff.addr[3:2] +: 32] = hwdata; // [RULE_16]
            end
            if (dph_ff.addr[7:4] == `SSCU_OFF_SRC_B >> 4) begin
                nxt_src_b[32*dph_ff.addr[3:2] +: 32] = hwdata; // [RULE_16]
            end
            if (dph_ff.addr == `SSCU_OFF_CTRL)     nxt_ctrl = hwdata;
            if (dph_ff.addr == `SSCU_OFF_LEN_DATA) nxt_len_data = hwdata;
            if (dph_ff.addr == `SSCU_OFF_LEN_ACC)  nxt_len_acc = hwdata;
            if (dph_ff.addr == `SSCU_OFF_CMD) wr_go = hwdata[`SSCU_CMD_GO_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: one evaluation cycle, then the results are latched.
    always_comb begin
        nxt_state = state_ff;
        nxt_res   = res_ff;
        nxt_cnt   = cnt_ff;
        nxt_done  = done_ff;
        unique case (state_ff)
            sscu_pkg::ST_IDLE: begin
                if (wr_go) begin
                    nxt_state = sscu_pkg::ST_RUN;
                    nxt_done  = 1'b0;
                end
            end
            sscu_pkg::ST_RUN: begin
                nxt_state = sscu_pkg::ST_IDLE;
                nxt_done  = 1'b1;
                // Index forms leave the vector result untouched.
                if (op == sscu_pkg::OP_EXP_INDEX ||
                    op == sscu_pkg::OP_IMP_INDEX) begin
                    nxt_cnt = {27'h0000000, calc_idx}; // [RULE_10]
                end else begin
                    nxt_res = calc_vec; // [RULE_10]
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            src_a_ff    <= `SSCU_DATA_RST;
            src_b_ff    <= `SSCU_DATA_RST;
            ctrl_ff     <= `SSCU_CTRL_RST;
            len_data_ff <= `SSCU_LEN_RST;
            len_acc_ff  <= `SSCU_LEN_RST;
            res_ff      <= `SSCU_DATA_RST;
            cnt_ff      <= `SSCU_LEN_RST;
            done_ff     <= 1'b0;
            hrdata_ff   <= 32'h0000_0000;
            state_ff    <= sscu_pkg::ST_IDLE;
            dph_ff      <= '0;
        end else if (ce) begin
            src_a_ff    <= nxt_src_a;
            src_b_ff    <= nxt_src_b;
            ctrl_ff     <= nxt_ctrl;
            len_data_ff <= nxt_len_data;
            len_acc_ff  <= nxt_len_acc;
            res_ff      <= nxt_res;
            cnt_ff      <= nxt_cnt;
            done_ff     <= nxt_done;
            hrdata_ff   <= nxt_hrdata;
            state_ff    <= nxt_state;
            dph_ff      <= nxt_dph;
        end
    end

endmodule
`default_nettype wire

/* testbench/sscu_monitor.sv */
// Bus-level checks on the ports of the string compare unit.
`timescale 1ns/1ps
`default_nettype none
module sscu_monitor #(
    parameter int ELEMS = 16
) (
    input wire logic        clk,
    input wire logic        ce,
    input wire logic        rst_b,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp
);
    logic rd_take;

    assign rd_take = hsel && htrans == 2'h2 && !hwrite && hready && ce;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////
    hresp_okay_a:
        assert property (hresp == 1'b0) else $error("response not okay");
    ready_follows_ce_a:
        assert property (hreadyout == ce) else $error("ready not ce");
    misaligned_zero_a:
        assert property (rd_take && haddr[1:0] != 2'h0 |=> hrdata == 32'h0)
        else $error("misaligned read not zero");
    unmapped_zero_a:
        assert property (rd_take && haddr[7:0] >= 8'h44 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    read_hold_a:
        assert property (!rd_take |=> $stable(hrdata))
        else $error("read data moved without a read");
    frozen_hold_a:
        assert property (!ce [*2] |-> $stable(hrdata))
        else $error("read data moved while frozen");
    index_bound_a:
        assert property (rd_take && haddr == 32'h40 |=> hrdata <= 32'(ELEMS))
        else $error("index beyond element count");
    reset_clear_a:
        assert property (disable iff (1'b0) !rst_b |-> hrdata == 32'h0)
        else $error("read data not cleared in reset");
endmodule
bind sscu_top sscu_monitor #(.ELEMS(ELEMS)) sscu_monitor_i (
    .clk(clk), .ce(ce), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp)
);
`default_nettype wire

/* testbench/sscu_issue_model.sv */
// Issue-side bus master that delivers operands and fetches results.
`timescale 1ns/1ps
`default_nettype none
module sscu_issue_model (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Write data is inverted after its phase so a stale value never helps.
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        hwdata <= ~wd;
    endtask
endmodule
`default_nettype wire

/* testbench/simd_string_compare_unit_test.sv */
// Self-checking bench for the string compare unit.
`timescale 1ns/1ps
`include "sscu_consts.svh"
`default_nettype none
module simd_string_compare_unit_test;
    typedef struct packed {
        logic [2:0]   op;
        logic [7:0]   imm;
        logic [127:0] a;
        logic [127:0] b;
        logic [7:0]   la;
        logic [7:0]   lb;
        logic [127:0] exp;
    } sscu_row_t;

    localparam logic [127:0] LO1 = 128'hffff_ffff_ffff_ffff;
    localparam logic [127:0] A1  = 128'h41;
    localparam logic [127:0] B1  = 128'h4141_4141_4141_4141_4141_4141_4141_4130;
    localparam logic [127:0] BW  = 128'h0041_0041_0041_0041_0041_0041_0041_0000;
    localparam logic [127:0] BI  = 128'h4141_4141_4141_4141_4141_4141_4100_4130;

    sscu_row_t rows [15] = '{
        '{3'h0, 8'h00, 128'h1_0000_0000_0000_0005,
          128'h2_0000_0000_0000_0005, 8'h0, 8'h0, LO1},
        '{3'h1, 8'h00, {64'hffff_ffff_ffff_ffff, 64'h7},
          {64'h1, 64'h3}, 8'h0, 8'h0, LO1},
        '{3'h2, 8'h00, 128'h0000ffff_00010000_ffffffff_00001234,
          128'h1, 8'h0, 8'h0, 128'h1_ffff_ffff_0000_1234},
        '{3'h3, 8'h00, A1, B1, 8'h1, 8'h10, 128'h1},
        '{3'h3, 8'h40, A1, B1, 8'h1, 8'h10, 128'hf},
        '{3'h3, 8'h40, A1, B1, 8'h1, 8'h3, 128'h2},
        '{3'h4, 8'h00, A1, B1, 8'h1, 8'h10, 128'hfffe},
        '{3'h4, 8'h40, A1, B1, 8'h1, 8'h10, ~128'hff},
        '{3'h4, 8'h10, A1, B1, 8'h1, 8'h3, 128'hfff9},
        '{3'h4, 8'h30, A1, B1, 8'h1, 8'h3, 128'h1},
        '{3'h3, 8'h01, A1, BW, 8'h1, 8'h8, 128'h1},
        '{3'h3, 8'h01, A1, BW, 8'h0, 8'h8, 128'h8},
        '{3'h5, 8'h40, A1, BI, 8'h0, 8'h0, 128'h1},
        '{3'h6, 8'h00, A1, BI, 8'h0, 8'h0, 128'h2},
        '{3'h4, 8'h06, 128'h80, 128'h05ff7f, 8'h2, 8'h3, 128'h2}
    };
    sscu_row_t modes [3] = '{
        '{3'h4, 8'h04, 128'h80, 128'h05ff7f, 8'h2, 8'h3, 128'h0},
        '{3'h4, 8'h08, 128'h44332211, 128'h44992211, 8'h4, 8'h4,
          128'hfffb},
        '{3'h4, 8'h0c, 128'h4241, 128'h41424158, 8'h2, 8'h4, 128'h2}
    };

    logic        clk = 1'b0;
    logic        rst_b;
    logic        ce;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] s;
    logic [127:0] v;
    int          fails = 0;
    int          compares = 0;

    always #5 clk = ~clk;

    sscu_top sscu_top_i (
        .clk(clk), .ce(ce), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp)
    );
    sscu_issue_model sscu_issue_model_i (
        .clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        sscu_issue_model_i.xfer(a, 1'b1, d, x);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        sscu_issue_model_i.xfer(a, 1'b0, 32'h0, d);
    endtask
    task automatic wr128(input logic [7:0] a, input logic [127:0] d);
        for (int k = 0; k < 4; k++) wr(a + 8'(4 * k), d[32 * k +: 32]);
    endtask
    task automatic rd128(input logic [7:0] a, output logic [127:0] d);
        for (int k = 0; k < 4; k++) rd(a + 8'(4 * k), d[32 * k +: 32]);
    endtask
    task automatic check_word(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check_vec(input string n, input logic [127:0] e, g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic run_row(input sscu_row_t r);
        int n;
        wr128(`SSCU_OFF_SRC_A, r.a);
        wr128(`SSCU_OFF_SRC_B, r.b);
        wr(`SSCU_OFF_LEN_ACC, {24'h0, r.la});
        wr(`SSCU_OFF_LEN_DATA, {24'h0, r.lb});
        wr(`SSCU_OFF_CTRL, {21'h0, r.op, r.imm});
        wr(`SSCU_OFF_CMD, 32'h1);
        repeat (2) @(posedge clk);
        n = 0;
        s = 32'h0;
        while (s[1] !== 1'b1 && n < 20) begin
            rd(`SSCU_OFF_CMD, s);
            n++;
        end
        check_word("status", 32'h2, {30'h0, s[1:0]});
        if (r.op == 3'h3 || r.op == 3'h5) begin
            rd(`SSCU_OFF_COUNT, s);
            check_word("count", r.exp[31:0], s);
        end else begin
            rd128(`SSCU_OFF_RES, v);
            check_vec("result", r.exp, v);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (50000) @(posedge clk);
        fails++;
        complete_run;
    end

    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        rd(`SSCU_OFF_CTRL, s);
        check_word("ctrl reset", 32'h0, s);
        rd128(`SSCU_OFF_RES, v);
        check_vec("result reset", 128'h0, v);
        foreach (rows[i]) run_row(rows[i]);
        foreach (modes[i]) run_row(modes[i]);
        wr(`SSCU_OFF_CTRL, 32'h6ff);
        @(posedge clk);
        ce <= 1'b0;
        fork
            rd(`SSCU_OFF_CTRL, s);
            begin
                repeat (4) @(posedge clk);
                ce <= 1'b1;
            end
        join
        check_word("ctrl frozen", 32'h6ff, s);
        rd(8'h21, s);
        check_word("misaligned", 32'h0, s);
        rd(8'h80, s);
        check_word("unmapped", 32'h0, s);
        // A second reset in mid-run must clear state left by earlier rows.
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        rd(`SSCU_OFF_CTRL, s);
        check_word("ctrl after reset", 32'h0, s);
        rd(`SSCU_OFF_COUNT, s);
        check_word("count after reset", 32'h0, s);
        complete_run;
    end
endmodule
`default_nettype wire
